// File: sdf_pkg.sv
package sdf_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int SDF_NUM_CH = 6;
  localparam int SDF_ACC_W  = 32;
  localparam int SDF_SUM_W  = 36;
  localparam int SDF_OUT_W  = 24;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses) and field positions
  // ------------------------------------------------------------------
  localparam logic [5:0] SDF_OFS_CTRL   = 6'h00;
  localparam logic [5:0] SDF_OFS_RESYNC = 6'h04;
  localparam logic [5:0] SDF_OFS_CHCFG  = 6'h08;
  localparam logic [5:0] SDF_OFS_STATUS = 6'h0c;
  localparam logic [5:0] SDF_OFS_DATA0  = 6'h10;
  localparam logic [5:0] SDF_OFS_DATA5  = 6'h24;

  localparam int SDF_CTRL_RATIO_LSB = 0;
  localparam int SDF_CTRL_EN_LSB    = 8;
  localparam int SDF_STAT_FAST_BIT  = 8;
  localparam int SDF_STAT_CONVERSION_READY_N_BIT  = 9;
  localparam int SDF_STAT_CONV_LSB  = 16;
  localparam int SDF_CFG_NIB_W      = 4;

  // ------------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------------
  localparam logic [2:0]  SDF_RATIO_RST      = 3'h0;
  localparam logic [5:0]  SDF_EN_RST         = 6'h3f;
  localparam logic [3:0]  SDF_RATIO_LOG2_MIN = 4'h7;  // Ratio 128
  localparam logic [3:0]  SDF_S3_LOG2_MAX    = 4'ha;  // Sinc3 ratio 1024
  localparam logic [1:0]  SDF_FAST_CONVS     = 2'h2;
  localparam int          SDF_FRAC_BITS      = 23;
  localparam logic [15:0] SDF_SETTLE_MAX     = 16'hffff;

  // Settling cycles, index = ratio code
  localparam logic [7:0][15:0] SDF_SETTLE_CYCLES = {
    16'h8258, 16'h4258, 16'h2258, 16'h1258,
    16'h0a58, 16'h0658, 16'h0458, 16'h0358
  };

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDF_BUS_IDLE = 2'b00,
    SDF_BUS_WAIT = 2'b01,
    SDF_BUS_ACK  = 2'b10
  } sdf_bus_t;

  typedef struct packed {
    logic [SDF_ACC_W-1:0] integ1;
    logic [SDF_ACC_W-1:0] integ2;
    logic [SDF_ACC_W-1:0] integ3;
    logic [SDF_ACC_W-1:0] comb1;
    logic [SDF_ACC_W-1:0] comb2;
    logic [SDF_ACC_W-1:0] comb3;
    logic [SDF_SUM_W-1:0] sinc1Acc;
    logic [15:0]          fastAcc;
    logic [15:0]          settleCnt;
  } sdf_chan_t;

  typedef struct packed {
    sdf_bus_t                   bus;
    logic                       waitreq;
    logic [31:0]                rdata;
    logic [2:0]                 ratioSel;
    logic [SDF_NUM_CH-1:0]      chanEn;
    logic [23:0]                chanCfg;
    logic                       modPhase;
    logic [13:0]                sampleCnt;
    logic [1:0]                 convCount;
    logic [7:0]                 convTotal;
    logic                       drdyN;
    logic [SDF_NUM_CH-1:0]      settled;
    sdf_chan_t [SDF_NUM_CH-1:0] ch;
  } sdf_state_t;

  localparam sdf_state_t SDF_STATE_RST = '{
    bus:      SDF_BUS_IDLE,
    waitreq:  1'b1,
    drdyN:    1'b1,
    ratioSel: SDF_RATIO_RST,
    chanEn:   SDF_EN_RST,
    default:  '0
  };

endpackage : sdf_pkg

// File: sdf_mem_if.sv
interface sdf_mem_if;
  import sdf_pkg::*;

  logic [SDF_NUM_CH-1:0]                wrEn;
  logic [SDF_NUM_CH-1:0][SDF_OUT_W-1:0] wrData;
  logic [2:0]                           rdAddr;
  logic [SDF_OUT_W-1:0]                 rdData;

  modport host (output wrEn, output wrData, output rdAddr, input rdData);
  modport mem  (input wrEn, input wrData, input rdAddr, output rdData);

endinterface : sdf_mem_if

// File: sdf_result_mem.sv
module sdf_result_mem
  import sdf_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Filter side
  sdf_mem_if.mem    port
);

  logic [SDF_NUM_CH-1:0][SDF_OUT_W-1:0] words_q;
  logic [SDF_OUT_W-1:0]                 rdData_q;

  // ------------------------------------------------------------------
  // Storage, one word per channel, all written on the same boundary
  // ------------------------------------------------------------------
  for (genvar g = 0; g < SDF_NUM_CH; g++) begin : gWord
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        words_q[g] <= '0;
      end else if (port.wrEn[g]) begin
        words_q[g] <= port.wrData[g];
      end
    end
  end

  // Registered read port; out-of-range index reads zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= '0;
    end else if (port.rdAddr < 3'(SDF_NUM_CH)) begin
      rdData_q <= words_q[port.rdAddr];
    end else begin
      rdData_q <= '0;
    end
  end

  assign port.rdData = rdData_q;

endmodule : sdf_result_mem

// File: sdf_decim_filter.sv
// Operation
// - Sinc-type FIR low-pass averages modulator bitstream
// - One output word per OSR modulator samples
// - Modulator sample rate is half master clock
// - Three-bit field selects one of eight ratios
// - Output rates scale with master clock frequency
// - Sinc1 fast-settling path after reset
// - Switch permanently to sinc3 after two conversions
// - Ratios up to 1024: sinc3 feeds output directly
// - Ratios 2048 up: sinc3 at 1024, then sinc1
// - Trailing sinc1 decimates by ratio over 1024
// - Response nulls at multiples of output rate
// - Restart settling on enable, config change, resync
// - Unsettled results still presented, never gated
// - First ready after settling interval is settled
// - Settling cycles per ratio from fixed table
module sdf_decim_filter
  import sdf_pkg::*;
#(
  parameter logic [7:0][15:0] SETTLE_CYCLES = SDF_SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Modulator bitstreams and sample strobe
  input  wire logic [SDF_NUM_CH-1:0] modBit,
  output logic                       modSampleStrobe,
  // Avalon-MM slave
  input  wire logic [5:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // Data ready
  output logic                       conversion_ready_n
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  sdf_state_t st_q;
  sdf_state_t st_d;

  sdf_mem_if memBus ();

  logic                  sampleStb;
  logic                  s3End;
  logic                  allEnd;
  logic [3:0]            kOsr;
  logic [3:0]            kS3;
  logic [13:0]           s3Mask;
  logic [13:0]           osrMax;
  logic [5:0]            eFast;
  logic [5:0]            eSlow;
  logic                  isData;
  logic [3:0]            dataIdx;
  logic [31:0]           rdMux;
  logic [31:0]           wrMerged;
  logic                  resyncAll;
  logic [SDF_NUM_CH-1:0] restart;
  logic [15:0]           settleTarget;
  logic [SDF_ACC_W-1:0]  xIn    [SDF_NUM_CH];
  logic [SDF_ACC_W-1:0]  c1     [SDF_NUM_CH];
  logic [SDF_ACC_W-1:0]  c2     [SDF_NUM_CH];
  logic [SDF_ACC_W-1:0]  c3     [SDF_NUM_CH];
  logic [SDF_SUM_W-1:0]  total  [SDF_NUM_CH];
  logic [SDF_SUM_W-1:0]  fastRaw[SDF_NUM_CH];

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Normalise a word of full scale 2**e to 24 bits, saturating at +FS
  function automatic logic [SDF_OUT_W-1:0] sdfScale(
    input logic [SDF_SUM_W-1:0] raw,
    input logic [5:0]           e
  );
    logic signed [59:0] w;
    w = 60'(signed'(raw)) <<< SDF_FRAC_BITS;
    w = w >>> e;
    if (w > 60'sh000_0000_007f_ffff) begin
      return 24'h7fffff;
    end else if (w < -60'sh000_0000_0080_0000) begin
      return 24'h800000;
    end
    return w[SDF_OUT_W-1:0];
  endfunction : sdfScale

  // Byte-lane merge for partial writes
  function automatic logic [31:0] sdfMerge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return m;
  endfunction : sdfMerge

  // ------------------------------------------------------------------
  // Ratio decode and decimation boundaries
  // ------------------------------------------------------------------
  always_comb begin
    kOsr      = SDF_RATIO_LOG2_MIN + {1'b0, st_q.ratioSel};
    kS3       = (kOsr > SDF_S3_LOG2_MAX) ? SDF_S3_LOG2_MAX : kOsr;
    osrMax    = (14'h0001 << kOsr) - 14'h0001;
    s3Mask    = (14'h0001 << kS3) - 14'h0001;
    eFast     = {2'b00, kOsr};
    eSlow     = 6'({kS3, 1'b0}) + {2'b00, kOsr};
    sampleStb = st_q.modPhase;
    s3End     = (st_q.sampleCnt & s3Mask) == s3Mask;
    allEnd    = st_q.sampleCnt == osrMax;
    settleTarget = SETTLE_CYCLES[st_q.ratioSel];
  end

  // ------------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------------
  always_comb begin
    dataIdx  = avs_address[5:2] - SDF_OFS_DATA0[5:2];
    isData   = (avs_address >= SDF_OFS_DATA0) && (avs_address <= SDF_OFS_DATA5)
               && (avs_address[1:0] == 2'b00);
    rdMux    = '0;
    wrMerged = '0;
    if (avs_address == SDF_OFS_CTRL) begin
      rdMux[SDF_CTRL_RATIO_LSB +: 3]        = st_q.ratioSel;
      rdMux[SDF_CTRL_EN_LSB +: SDF_NUM_CH]  = st_q.chanEn;
    end else if (avs_address == SDF_OFS_CHCFG) begin
      rdMux[23:0] = st_q.chanCfg;
    end else if (avs_address == SDF_OFS_STATUS) begin
      rdMux[SDF_NUM_CH-1:0]            = st_q.settled;
      rdMux[SDF_STAT_FAST_BIT]         = st_q.convCount < SDF_FAST_CONVS;
      rdMux[SDF_STAT_CONVERSION_READY_N_BIT]         = st_q.drdyN;
      rdMux[SDF_STAT_CONV_LSB +: 8]    = st_q.convTotal;
    end else if (isData) begin
      rdMux[SDF_OUT_W-1:0] = memBus.rdData;
    end
    wrMerged = sdfMerge(rdMux, avs_writedata, avs_byteenable);
  end

  // Result memory: conversion words in, bus reads out
  assign memBus.rdAddr = dataIdx[2:0];

  sdf_result_mem uMem (
    .clk    (clk),
    .resetn (resetn),
    .port   (memBus.mem)
  );

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    resyncAll     = 1'b0;
    restart       = '0;
    memBus.wrEn   = '0;
    memBus.wrData = '0;
    for (int i = 0; i < SDF_NUM_CH; i++) begin
      xIn[i]     = '0;
      c1[i]      = '0;
      c2[i]      = '0;
      c3[i]      = '0;
      total[i]   = '0;
      fastRaw[i] = '0;
    end

    // Bus handshake: request seen, memory read, answer with waitrequest low
    unique case (st_q.bus)
      SDF_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_d.bus = SDF_BUS_WAIT;
        end
      end
      SDF_BUS_WAIT: begin
        st_d.bus     = SDF_BUS_ACK;
        st_d.waitreq = 1'b0;
        st_d.rdata   = rdMux;
      end
      SDF_BUS_ACK: begin
        st_d.bus     = SDF_BUS_IDLE;
        st_d.waitreq = 1'b1;
        if (avs_write && avs_address == SDF_OFS_CTRL) begin
          st_d.ratioSel = wrMerged[SDF_CTRL_RATIO_LSB +: 3];
          st_d.chanEn   = wrMerged[SDF_CTRL_EN_LSB +: SDF_NUM_CH];
          resyncAll     = st_d.ratioSel != st_q.ratioSel;
        end else if (avs_write && avs_address == SDF_OFS_RESYNC) begin
          resyncAll = wrMerged[0];
        end else if (avs_write && avs_address == SDF_OFS_CHCFG) begin
          st_d.chanCfg = wrMerged[23:0];
        end
        // Reading a result releases the ready line early
        if (avs_read && isData) begin
          st_d.drdyN = 1'b1;
        end
      end
      default: begin
        st_d.bus     = SDF_BUS_IDLE;
        st_d.waitreq = 1'b1;
      end
    endcase

    // Modulator runs every other master clock
    st_d.modPhase = ~st_q.modPhase;
    if (sampleStb) begin
      st_d.sampleCnt = allEnd ? 14'h0000 : st_q.sampleCnt + 14'h0001;
      // Release ready one sample ahead so every conversion gives a fall
      if (st_q.sampleCnt == osrMax - 14'h0001) begin
        st_d.drdyN = 1'b1;
      end
    end
    if (sampleStb && allEnd) begin
      if (st_q.convCount < SDF_FAST_CONVS) begin
        st_d.convCount = st_q.convCount + 2'h1;
      end
      st_d.convTotal = st_q.convTotal + 8'h01;
      if (|st_q.chanEn) begin
        st_d.drdyN = 1'b0;
      end
    end

    // Per-channel filter paths; both run in parallel from reset
    for (int i = 0; i < SDF_NUM_CH; i++) begin
      xIn[i] = modBit[i] ? 32'h0000_0001 : 32'hffff_ffff;
      c1[i]  = st_q.ch[i].integ3 - st_q.ch[i].comb1;
      c2[i]  = c1[i] - st_q.ch[i].comb2;
      c3[i]  = c2[i] - st_q.ch[i].comb3;
      total[i]   = st_q.ch[i].sinc1Acc + SDF_SUM_W'(signed'(c3[i]));
      // Operands widened one by one so the 16-bit sum keeps its sign
      fastRaw[i] = SDF_SUM_W'(signed'(st_q.ch[i].fastAcc))
                   + SDF_SUM_W'(signed'(xIn[i][15:0]));
      if (sampleStb) begin
        st_d.ch[i].integ1  = st_q.ch[i].integ1 + xIn[i];
        st_d.ch[i].integ2  = st_q.ch[i].integ2 + st_q.ch[i].integ1;
        st_d.ch[i].integ3  = st_q.ch[i].integ3 + st_q.ch[i].integ2;
        st_d.ch[i].fastAcc = st_q.ch[i].fastAcc + xIn[i][15:0];
      end
      // Sinc3 comb at its own boundary: ratio, or 1024 above that
      if (sampleStb && s3End) begin
        st_d.ch[i].comb1    = st_q.ch[i].integ3;
        st_d.ch[i].comb2    = c1[i];
        st_d.ch[i].comb3    = c2[i];
        st_d.ch[i].sinc1Acc = allEnd ? '0 : total[i];
      end
      // Output word on the shared boundary; nulls follow from the
      // boxcar length equal to the ratio
      if (sampleStb && allEnd) begin
        st_d.ch[i].fastAcc = '0;
        memBus.wrEn[i]     = st_q.chanEn[i];
        if (st_q.convCount < SDF_FAST_CONVS) begin
          memBus.wrData[i] = sdfScale(fastRaw[i], eFast);
        end else begin
          memBus.wrData[i] = sdfScale(total[i], eSlow);
        end
        if (st_q.ch[i].settleCnt >= settleTarget) begin
          st_d.settled[i] = 1'b1;
        end
      end
      if (st_q.ch[i].settleCnt != SDF_SETTLE_MAX) begin
        st_d.ch[i].settleCnt = st_q.ch[i].settleCnt + 16'h0001;
      end
    end

    // Restart: resync, ratio change, channel off or re-enabled, cfg change
    for (int i = 0; i < SDF_NUM_CH; i++) begin
      restart[i] = resyncAll || !st_d.chanEn[i]
                   || (st_d.chanEn[i] && !st_q.chanEn[i])
                   || (st_d.chanCfg[SDF_CFG_NIB_W*i +: SDF_CFG_NIB_W]
                       != st_q.chanCfg[SDF_CFG_NIB_W*i +: SDF_CFG_NIB_W]);
      if (restart[i]) begin
        st_d.ch[i]      = '0;
        st_d.settled[i] = 1'b0;
      end
    end
    if (resyncAll) begin
      st_d.sampleCnt = '0;
      // Strobe phase keeps running so the modulator rate never jumps
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= SDF_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign modSampleStrobe    = st_q.modPhase;
  assign avs_readdata       = st_q.rdata;
  assign avs_waitrequest    = st_q.waitreq;
  assign conversion_ready_n = st_q.drdyN;

endmodule : sdf_decim_filter

// File: sdf_chk.sv
module sdf_chk
  import sdf_pkg::*;
#(
  parameter logic [7:0][15:0] SETTLE_CYCLES = SDF_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Modulator side
  input wire logic [SDF_NUM_CH-1:0] modBit,
  input wire logic                  modSampleStrobe,
  // Avalon-MM slave
  input wire logic [5:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  // Data ready
  input wire logic                  conversion_ready_n
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic        crQ;
  logic [15:0] gapQ;
  logic        rdDone;
  logic        dataRd;
  // Cycles since the last ready fall; saturates so it never wraps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crQ  <= 1'b1;
      gapQ <= 16'h0;
    end else begin
      crQ  <= conversion_ready_n;
      gapQ <= (crQ && !conversion_ready_n) ? 16'h0 : gapQ + 16'(gapQ != 16'hffff);
    end
  end
  // Completed reads, and those that hit a result word
  assign rdDone = avs_read && !avs_waitrequest;
  assign dataRd = rdDone && avs_address >= SDF_OFS_DATA0 && avs_address <= SDF_OFS_DATA5
                  && avs_address[1:0] == 2'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_strobe_rate: assert property ($past(resetn) |-> modSampleStrobe != $past(modSampleStrobe))
    else $error("sample strobe did not toggle");
  chk_fall_strobe: assert property ($fell(conversion_ready_n) |-> $past(modSampleStrobe))
    else $error("ready fell outside a sample cycle");
  chk_fall_spacing: assert property ($fell(conversion_ready_n) |-> gapQ >= 16'd255)
    else $error("conversions closer than the smallest ratio");
  chk_ready_holds: assert property ($fell(conversion_ready_n) && avs_waitrequest ##1 avs_waitrequest
                                    |-> !conversion_ready_n)
    else $error("ready released without a read");
  chk_ready_release: assert property (dataRd && !conversion_ready_n |=> conversion_ready_n)
    else $error("ready stayed low after a result read");
  chk_wait_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest)
    else $error("bus access not answered in time");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest)
                                   |-> $stable(avs_readdata))
    else $error("read data changed between answers");
  chk_data_upper: assert property (dataRd |-> avs_readdata[31:24] == 8'h0)
    else $error("result word upper byte not zero");
  chk_unmapped_zero: assert property (rdDone && avs_address > SDF_OFS_DATA5
                                      |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  cover property ($fell(conversion_ready_n));
  cover property (dataRd);
  cover property (avs_write && !avs_waitrequest);
endmodule : sdf_chk

bind sdf_decim_filter sdf_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .clk(clk), .resetn(resetn), .modBit(modBit), .modSampleStrobe(modSampleStrobe),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .conversion_ready_n(conversion_ready_n)
);

// File: sdf_mod_model.sv
module sdf_mod_model
  import sdf_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Stream selection
  input  wire logic                       modSampleStrobe,
  input  wire logic [SDF_NUM_CH-1:0][1:0] mode,
  // Bitstream
  output logic      [SDF_NUM_CH-1:0]      modBit
);
  logic [SDF_NUM_CH-1:0] altQ;
  // One new bit per taken sample, so the stream runs at half the clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      altQ <= '0;
    end else if (modSampleStrobe) begin
      altQ <= ~altQ;
    end
  end
  // Mode 0 all -1, mode 1 all +1, mode 2 alternating with zero mean
  always_comb begin
    for (int i = 0; i < SDF_NUM_CH; i++) begin
      modBit[i] = (mode[i] == 2'h2) ? altQ[i] : mode[i][0];
    end
  end
endmodule : sdf_mod_model

// File: sdf_tb.sv
module testbench
  import sdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  // Settling just past one conversion, so each ratio shows both states
  function automatic logic [7:0][15:0] mk_settle();
    logic [7:0][15:0] t;
    for (int i = 0; i < 8; i++) t[i] = 16'((256 << i) + 44);
    return t;
  endfunction : mk_settle
  localparam logic [7:0][15:0] SETTLE = mk_settle();
  localparam int               TMO    = 95000;
  logic                       clk             = 1'b0;
  logic                       resetn          = 1'b0;
  logic [SDF_NUM_CH-1:0]      modBit;
  logic                       modSampleStrobe;
  logic [5:0]                 avs_address     = 6'h0;
  logic                       avs_read        = 1'b0;
  logic                       avs_write       = 1'b0;
  logic [31:0]                avs_writedata   = 32'h0;
  logic [3:0]                 avs_byteenable  = 4'hf;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic                       conversion_ready_n;
  logic [SDF_NUM_CH-1:0][1:0] mode            = '0;
  logic                       crPrev          = 1'b1;
  logic [31:0]                rd;
  int                         cyc             = 0;
  int                         t0;
  int                         error_cnt       = 0;
  int                         n_tests         = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  sdf_decim_filter #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk(clk), .resetn(resetn), .modBit(modBit), .modSampleStrobe(modSampleStrobe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conversion_ready_n(conversion_ready_n)
  );
  sdf_mod_model u_mod (
    .clk(clk), .resetn(resetn), .modSampleStrobe(modSampleStrobe), .mode(mode),
    .modBit(modBit)
  );
  // Cycle count, ready history and the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    crPrev <= conversion_ready_n;
    if (cyc == TMO) begin
      error_cnt++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_cyc(input string nm, input int e, input int g);
    n_tests++;
    if (g != e) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_cyc
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    cmp_cyc("latency", 3, n);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Returns just after the edge at which ready fell
  task automatic wait_fall();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(crPrev === 1'b1 && conversion_ready_n === 1'b0) && n < 40000);
    cmp_cyc("ready fall", 1, int'(n < 40000));
  endtask : wait_fall
  task automatic new_modes();
    @(posedge clk);
    for (int i = 0; i < SDF_NUM_CH; i++) mode[i] <= 2'($urandom_range(2));
  endtask : new_modes
  // Integer model: mean of a window of +1/-1 samples, 23 fraction bits, saturating
  function automatic logic [31:0] expv(input logic [1:0] m, input int osr);
    longint s;
    longint v;
    s = (m == 2'h1) ? osr : (m == 2'h0) ? -osr : 0;
    v = (s <<< SDF_FRAC_BITS) / osr;
    if (v > 64'sd8388607) v = 8388607;
    return 32'(v[23:0]);
  endfunction : expv
  task automatic chk_data(input int osr);
    for (int i = 0; i < SDF_NUM_CH; i++) begin
      bus(1'b0, SDF_OFS_DATA0 + 6'(4 * i), 32'h0, 4'hf);
      cmp("data", expv(mode[i], osr), rd);
    end
  endtask : chk_data
  task automatic status();
    bus(1'b0, SDF_OFS_STATUS, 32'h0, 4'hf);
  endtask : status
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h8bfe));
    new_modes();
    repeat (7) @(posedge clk);
    resetn <= 1'b1;
    // Reset state and the fast-settling start
    bus(1'b0, SDF_OFS_CTRL, 32'h0, 4'hf);
    cmp("ctrl", 32'h00003f00, rd);
    status();
    cmp("fast", 32'h1, 32'(rd[SDF_STAT_FAST_BIT]));
    wait_fall();
    chk_data(128);
    wait_fall();
    t0 = cyc;
    wait_fall();
    cmp_cyc("period", 256, cyc - t0);
    status();
    cmp("fast", 32'h0, 32'(rd[SDF_STAT_FAST_BIT]));
    cmp("convs", 32'h3, 32'(rd[23:16]));
    // Every ratio code, descending so each write is a real change
    for (int c = 7; c >= 0; c--) begin
      new_modes();
      bus(1'b1, SDF_OFS_CTRL, 32'(c), 4'h1);
      bus(1'b0, SDF_OFS_CTRL, 32'h0, 4'hf);
      cmp("ctrl", 32'h00003f00 | 32'(c), rd);
      if (c < 6) begin
        wait_fall();
        status();
        cmp("settled", 32'h0, 32'(rd[5:0]));
        wait_fall();
        t0 = cyc;
        status();
        cmp("settled", 32'h3f, 32'(rd[5:0]));
        wait_fall();
        cmp_cyc("period", 256 << c, cyc - t0);
        // Results before this point are ignored, though the last two already read as settled
        wait_fall();
        chk_data(128 << c);
      end
    end
    // Channel config change restarts one channel, resync restarts all
    bus(1'b1, SDF_OFS_CHCFG, 32'h00000100, 4'hf);
    wait_fall();
    status();
    cmp("settled", 32'h3b, 32'(rd[5:0]));
    bus(1'b1, SDF_OFS_RESYNC, 32'h1, 4'hf);
    wait_fall();
    status();
    cmp("settled", 32'h0, 32'(rd[5:0]));
    cmp("fast", 32'h0, 32'(rd[SDF_STAT_FAST_BIT]));
    // Channel 0 switched off stays unsettled, the others settle
    bus(1'b1, SDF_OFS_CTRL, 32'h00003e00, 4'hf);
    wait_fall();
    status();
    cmp("settled", 32'h3e, 32'(rd[5:0]));
    bus(1'b0, 6'h3c, 32'h0, 4'hf);
    cmp("unmapped", 32'h0, rd);
    results();
  end
endmodule : testbench
